// ===== src/bsic_pkg.sv
// constants shared by the bridge strap and interrupt configuration block
package bsic_pkg;
    localparam logic [7:0] BSIC_MISC_A_OFS = 8'h40;
    localparam logic [7:0] BSIC_MISC_TWO_OFS = 8'h44;
    localparam logic [7:0] BSIC_STRAP_OFS = 8'h48;
    localparam logic [7:0] BSIC_MISC_B_OFS = 8'h50;
    localparam logic [7:0] BSIC_MISC_TWO_B_OFS = 8'h54;
    localparam logic [7:0] BSIC_IRQ_STATUS_OFS = 8'h60;
    localparam logic [7:0] BSIC_IRQ_ENABLE_OFS = 8'h64;
    localparam logic [7:0] BSIC_IRQ_CLEAR_OFS = 8'h68;
    localparam logic [7:0] BSIC_MASK_OFS = 8'h6c;
    localparam int BSIC_ROUTE_BIT = 0;
    localparam int BSIC_FREQ_BIT = 1;
    localparam int BSIC_SINGLE_SLOT_BIT = 2;
    localparam int BSIC_NMI_EN_BIT = 0;
    localparam int BSIC_COMPAT_BIT = 0;
    localparam int BSIC_HP_EN_A_BIT = 2;
    localparam int BSIC_HP_EN_B_BIT = 3;
    localparam int BSIC_BUFFER_DELAY_VALUE_LSB = 8;
    localparam logic [31:0] BSIC_MISC_TWO_RST = 32'h0000_0000;
    localparam logic [3:0] BSIC_BUFFER_DELAY_VALUE_DEFAULT = 4'ha;
    localparam int BSIC_TAP_PS_NUM = 1250;
    localparam int BSIC_FREQ_SLOW_MHZ = 33;
    localparam int BSIC_FREQ_FAST_MHZ = 66;
endpackage

// ===== src/bsic_top.sv
// strap latch, miscellaneous registers and legacy interrupt combining for two bridges
// What this block does
// - latch single-slot strap at power-good rise from per-bridge pins; read-only
// - single-slot low plus hot-plug enabled means one slot without isolation switches
// - read-only frequency bit: 0 is 33 MHz, 1 is 66 MHz, from strap
// - legacy irq low when a routed bridge's slot input low and mask set
// - legacy irq outputs are open drain, released when inactive
// - misc two upper bits are plain storage; register resets to zero
// - nmi enable set makes each rise of a bridge's combined parity-or-system error request nmi, not a second error while one is held
// - boot strap register takes strap values at power-good rise
// - buffer delay field bits 11:8 reports tap step value, read-only
// - bit 3 latches serial load pin: hot-plug enable for bridge b
// - bit 2 latches serial out data pin: hot-plug enable for bridge a
// - compat bit routes compat-flagged host accesses to secondary bus
//
// Chosen here: the strobed register port.
module bsic_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic power_good,
    input wire logic hotplug_serial_in_clock,
    input wire logic bridge_b_grant2_n,
    input wire logic hotplug_serial_load_n,
    input wire logic hotplug_serial_out_data,
    input wire logic compat_strap,
    input wire logic freq_strap_a,
    input wire logic freq_strap_b,
    input wire logic [3:0] buffer_delay_strap,
    input wire logic [3:0] slot_irq_in_a_n,
    input wire logic [3:0] slot_irq_in_b_n,
    input wire logic perr_a_n,
    input wire logic serr_a_n,
    input wire logic perr_b_n,
    input wire logic serr_b_n,
    input wire logic host_compat_req,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [3:0] legacy_irq_out_n_o,
    output logic [3:0] legacy_irq_out_n_oe,
    output logic compat_to_secondary,
    output logic hotplug_single_slot_mode_a,
    output logic hotplug_single_slot_mode_b,
    output logic nmi_req,
    output logic irq
);
    // two-flop synchronisers for every pin input
    // reset loads each pin's idle level so no false edge follows reset
    localparam int NSYNC = 25;
    localparam logic [NSYNC-1:0] SYNC_IDLE = 25'h1ffe;
    logic [NSYNC-1:0] sync_in;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    assign sync_in = {power_good, hotplug_serial_in_clock, bridge_b_grant2_n,
                      hotplug_serial_load_n, hotplug_serial_out_data, compat_strap,
                      freq_strap_a, freq_strap_b, buffer_delay_strap,
                      slot_irq_in_a_n, slot_irq_in_b_n,
                      perr_a_n, serr_a_n, perr_b_n, serr_b_n, 1'b0};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= SYNC_IDLE;
            sync2_reg <= SYNC_IDLE;
        end else begin
            sync1_reg <= sync_in;
            sync2_reg <= sync1_reg;
        end
    end

    // synchronised levels, in the order of the concatenation above
    logic pg_s;
    logic hsic_s;
    logic gnt2_s;
    logic hsil_s;
    logic hsod_s;
    logic compat_s;
    logic freq_a_s;
    logic freq_b_s;
    logic [3:0] buffer_delay_value_s;
    logic [3:0] slot_irq_in_n_a_s;
    logic [3:0] slot_irq_in_n_b_s;
    logic perr_a_s;
    logic serr_a_s;
    logic perr_b_s;
    logic serr_b_s;
    assign {pg_s, hsic_s, gnt2_s, hsil_s, hsod_s, compat_s, freq_a_s, freq_b_s, buffer_delay_value_s,
            slot_irq_in_n_a_s, slot_irq_in_n_b_s, perr_a_s, serr_a_s, perr_b_s, serr_b_s} =
        sync2_reg[NSYNC-1:1];

    // power-good rising edge detect on the synchronised level
    // straps are latched only once the level has crossed the synchroniser
    logic pg_d_reg;
    logic pg_rise;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pg_d_reg <= 1'b0;
        end else begin
            pg_d_reg <= pg_s;
        end
    end
    assign pg_rise = pg_s & ~pg_d_reg;

    // strap latches; software has no write path to them
    // single-slot resets high: switches are assumed until straps are known
    logic single_slot_a_reg;
    logic single_slot_b_reg;
    logic freq_a_reg;
    logic freq_b_reg;
    logic hp_en_a_reg;
    logic hp_en_b_reg;
    logic [3:0] buffer_delay_value_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            single_slot_a_reg <= 1'b1;
            single_slot_b_reg <= 1'b1;
            freq_a_reg <= 1'b0;
            freq_b_reg <= 1'b0;
            hp_en_a_reg <= 1'b0;
            hp_en_b_reg <= 1'b0;
            buffer_delay_value_reg <= bsic_pkg::BSIC_BUFFER_DELAY_VALUE_DEFAULT;
        end else if (pg_rise) begin
            single_slot_a_reg <= hsic_s;
            single_slot_b_reg <= gnt2_s;
            freq_a_reg <= freq_a_s;
            freq_b_reg <= freq_b_s;
            hp_en_a_reg <= hsod_s;
            hp_en_b_reg <= hsil_s;
            buffer_delay_value_reg <= buffer_delay_value_s;
        end
    end

    // single-slot mode needs strap low and hot-plug on; board keeps the rest legal
    assign hotplug_single_slot_mode_a = ~single_slot_a_reg & hp_en_a_reg;
    assign hotplug_single_slot_mode_b = ~single_slot_b_reg & hp_en_b_reg;

    // writable control state
    logic route_a_reg;
    logic route_b_reg;
    logic [31:0] misc_two_a_reg;
    logic [31:0] misc_two_b_reg;
    logic compat_reg;
    logic [7:0] mask_reg;
    logic [2:0] irq_en_reg;
    logic [2:0] irq_stat_reg;
    logic wr_misc_a;
    logic wr_misc_b;
    logic wr_two_a;
    logic wr_two_b;
    logic wr_strap;
    logic wr_mask;
    logic wr_ien;
    logic wr_iclr;
    // one decode per register; unmapped offsets change nothing
    assign wr_misc_a = reg_wr && reg_addr == bsic_pkg::BSIC_MISC_A_OFS;
    assign wr_misc_b = reg_wr && reg_addr == bsic_pkg::BSIC_MISC_B_OFS;
    assign wr_two_a = reg_wr && reg_addr == bsic_pkg::BSIC_MISC_TWO_OFS;
    assign wr_two_b = reg_wr && reg_addr == bsic_pkg::BSIC_MISC_TWO_B_OFS;
    assign wr_strap = reg_wr && reg_addr == bsic_pkg::BSIC_STRAP_OFS;
    assign wr_mask = reg_wr && reg_addr == bsic_pkg::BSIC_MASK_OFS;
    assign wr_ien = reg_wr && reg_addr == bsic_pkg::BSIC_IRQ_ENABLE_OFS;
    assign wr_iclr = reg_wr && reg_addr == bsic_pkg::BSIC_IRQ_CLEAR_OFS;

    // route bits reset high; legacy lines pass only after software sets mask bits, which reset to zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            route_a_reg <= 1'b1;
            route_b_reg <= 1'b1;
        end else begin
            if (wr_misc_a) begin
                route_a_reg <= reg_wdata[bsic_pkg::BSIC_ROUTE_BIT];
            end
            if (wr_misc_b) begin
                route_b_reg <= reg_wdata[bsic_pkg::BSIC_ROUTE_BIT];
            end
        end
    end

    // bit 0 is the nmi enable; the upper bits are plain storage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            misc_two_a_reg <= bsic_pkg::BSIC_MISC_TWO_RST;
            misc_two_b_reg <= bsic_pkg::BSIC_MISC_TWO_RST;
        end else begin
            if (wr_two_a) begin
                misc_two_a_reg <= reg_wdata;
            end
            if (wr_two_b) begin
                misc_two_b_reg <= reg_wdata;
            end
        end
    end

    // compat default reloads from strap when power-good rises
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            compat_reg <= 1'b0;
        end else if (pg_rise) begin
            compat_reg <= compat_s;
        end else if (wr_strap) begin
            compat_reg <= reg_wdata[bsic_pkg::BSIC_COMPAT_BIT];
        end
    end
    assign compat_to_secondary = compat_reg & host_compat_req;

    // redirection mask bits: [3:0] bridge a, [7:4] bridge b
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_reg <= 8'h00;
        end else if (wr_mask) begin
            mask_reg <= reg_wdata[7:0];
        end
    end

    // legacy interrupt combining, one open-drain output per line
    // line i pairs mask bit i for bridge a and bit i+4 for bridge b
    // drive value stays low; the enable alone pulls, the board pull-up restores high
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_line
            logic act;
            assign act = (route_a_reg & ~slot_irq_in_n_a_s[gi] & mask_reg[gi])
                       | (route_b_reg & ~slot_irq_in_n_b_s[gi] & mask_reg[gi+4]);
            assign legacy_irq_out_n_o[gi] = 1'b0;
            assign legacy_irq_out_n_oe[gi] = act;
        end
    endgenerate

    // error edge per bridge, index 0 bridge a; a held error asks for nmi once
    // parity and system errors share one edge, whatever drove them
    logic [1:0] perr_s;
    logic [1:0] serr_s;
    logic [1:0] nmi_en;
    logic [1:0] err_d_reg;
    logic [1:0] err_now;
    logic [1:0] err_rise;
    logic [2:0] ev;
    assign perr_s = {perr_b_s, perr_a_s};
    assign serr_s = {serr_b_s, serr_a_s};
    assign nmi_en = {misc_two_b_reg[bsic_pkg::BSIC_NMI_EN_BIT],
                     misc_two_a_reg[bsic_pkg::BSIC_NMI_EN_BIT]};
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_d_reg <= 2'b00;
        end else begin
            err_d_reg <= err_now;
        end
    end

    genvar bi;
    generate
        for (bi = 0; bi < 2; bi++) begin : g_err
            assign err_now[bi] = ~perr_s[bi] | ~serr_s[bi];
            assign err_rise[bi] = err_now[bi] & ~err_d_reg[bi];
            assign ev[bi] = err_rise[bi] & nmi_en[bi];
        end
    endgenerate

    // status event sources: nmi bridge a, nmi bridge b, strap latch
    assign ev[2] = pg_rise;

    // registered so the pulse is one clean cycle per error edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nmi_req <= 1'b0;
        end else begin
            nmi_req <= ev[0] | ev[1];
        end
    end

    // enable and clear share the status layout
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_reg <= 3'h0;
        end else if (wr_ien) begin
            irq_en_reg <= reg_wdata[2:0];
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= 3'h0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~(wr_iclr ? reg_wdata[2:0] : 3'h0)) | ev;
        end
    end
    // level output: high until software clears the bit or its enable
    assign irq = |(irq_stat_reg & irq_en_reg);

    // read images of the mixed registers; reserved bits read zero
    logic [31:0] misc_a_word;
    logic [31:0] misc_b_word;
    logic [31:0] strap_word;
    // frequency bit is only meaningful while the bridge runs conventional mode
    always_comb begin
        misc_a_word = 32'h0000_0000;
        misc_a_word[bsic_pkg::BSIC_ROUTE_BIT] = route_a_reg;
        misc_a_word[bsic_pkg::BSIC_FREQ_BIT] = freq_a_reg;
        misc_a_word[bsic_pkg::BSIC_SINGLE_SLOT_BIT] = single_slot_a_reg;
    end

    always_comb begin
        misc_b_word = 32'h0000_0000;
        misc_b_word[bsic_pkg::BSIC_ROUTE_BIT] = route_b_reg;
        misc_b_word[bsic_pkg::BSIC_FREQ_BIT] = freq_b_reg;
        misc_b_word[bsic_pkg::BSIC_SINGLE_SLOT_BIT] = single_slot_b_reg;
    end

    always_comb begin
        strap_word = 32'h0000_0000;
        strap_word[bsic_pkg::BSIC_BUFFER_DELAY_VALUE_LSB +: 4] = buffer_delay_value_reg;
        strap_word[bsic_pkg::BSIC_HP_EN_B_BIT] = hp_en_b_reg;
        strap_word[bsic_pkg::BSIC_HP_EN_A_BIT] = hp_en_a_reg;
        strap_word[bsic_pkg::BSIC_COMPAT_BIT] = compat_reg;
    end

    // register read path, data one cycle after the strobe
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (reg_addr)
            bsic_pkg::BSIC_MISC_A_OFS: rd_mux = misc_a_word;
            bsic_pkg::BSIC_MISC_B_OFS: rd_mux = misc_b_word;
            bsic_pkg::BSIC_MISC_TWO_OFS: rd_mux = misc_two_a_reg;
            bsic_pkg::BSIC_MISC_TWO_B_OFS: rd_mux = misc_two_b_reg;
            bsic_pkg::BSIC_STRAP_OFS: rd_mux = strap_word;
            bsic_pkg::BSIC_IRQ_STATUS_OFS: rd_mux[2:0] = irq_stat_reg;
            bsic_pkg::BSIC_IRQ_ENABLE_OFS: rd_mux[2:0] = irq_en_reg;
            bsic_pkg::BSIC_MASK_OFS: rd_mux[7:0] = mask_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // data stand one cycle only, so a stale word is never taken twice
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule

// ===== tb/bsic_board.sv
// board model: strap resistors, power-good pin and pulled-up legacy interrupt lines
module bsic_board (
    input wire logic pg_on,
    input wire logic [3:0] line_o,
    input wire logic [3:0] line_oe,
    output logic power_good,
    output logic sic,
    output logic gnt2_n,
    output logic sil_n,
    output logic sod,
    output logic compat_s,
    output logic fa,
    output logic fb,
    output logic [3:0] buffer_delay_value,
    output logic [3:0] line_n
);
    timeunit 1ns;
    timeprecision 1ps;
    assign power_good = pg_on;
    assign sic = 1'b0;
    assign sod = 1'b1;
    // bridge b serves several devices
    assign gnt2_n = 1'b1;
    assign sil_n = 1'b1;
    assign compat_s = 1'b1;
    assign fa = 1'b1;
    assign fb = 1'b0;
    assign buffer_delay_value = 4'h7;
    // pull-up where released
    assign line_n = (line_oe & line_o) | ~line_oe;
endmodule

// ===== tb/bsic_checker.sv
// concurrent checks on the ports of the strap and interrupt configuration block
module bsic_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic power_good,
    input wire logic perr_a_n,
    input wire logic serr_a_n,
    input wire logic perr_b_n,
    input wire logic serr_b_n,
    input wire logic host_compat_req,
    input wire logic [3:0] slot_irq_in_a_n,
    input wire logic [3:0] slot_irq_in_b_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [3:0] legacy_irq_out_n_o,
    input wire logic [3:0] legacy_irq_out_n_oe,
    input wire logic compat_to_secondary,
    input wire logic hotplug_single_slot_mode_a,
    input wire logic hotplug_single_slot_mode_b,
    input wire logic nmi_req,
    input wire logic irq
);
    wire logic err_any;
    assign err_any = !(perr_a_n && serr_a_n && perr_b_n && serr_b_n);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // every slot input released for long enough to pass the synchroniser
    sequence s_lines_idle;
        (&slot_irq_in_a_n && &slot_irq_in_b_n) [*3];
    endsequence
    sequence s_strap_window;
        power_good && ($past(!power_good, 2) || $past(!power_good, 3) ||
            $past(!power_good, 4) || $past(!power_good, 5));
    endsequence
    property p_drive_low;
        legacy_irq_out_n_o == 4'h0;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("open drain drives high");
    property p_lines_idle;
        s_lines_idle |-> legacy_irq_out_n_oe == 4'h0;
    endproperty
    a_lines_idle: assert property (p_lines_idle) else $error("line pulled while idle");
    property p_compat;
        compat_to_secondary |-> host_compat_req;
    endproperty
    a_compat: assert property (p_compat) else $error("compat route without request");
    property p_nmi_cause;
        nmi_req |-> ($past(err_any, 2) || $past(err_any, 3) || $past(err_any, 4) ||
            $past(err_any, 5));
    endproperty
    a_nmi_cause: assert property (p_nmi_cause) else $error("nmi without error");
    property p_nmi_pulse;
        nmi_req |=> !nmi_req;
    endproperty
    a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi pulse too long");
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
    property p_irq_off;
        reg_wr && reg_addr == bsic_pkg::BSIC_IRQ_ENABLE_OFS && reg_wdata == 32'h0 |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq with all masked");
    property p_strap_hold;
        $changed({hotplug_single_slot_mode_a, hotplug_single_slot_mode_b}) |-> s_strap_window;
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap mode moved");
endmodule

bind bsic_top bsic_checker bsic_checker_inst (.core_clk(core_clk), .rst_n(rst_n),
    .power_good(power_good), .perr_a_n(perr_a_n), .serr_a_n(serr_a_n),
    .perr_b_n(perr_b_n), .serr_b_n(serr_b_n), .host_compat_req(host_compat_req),
    .slot_irq_in_a_n(slot_irq_in_a_n), .slot_irq_in_b_n(slot_irq_in_b_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .legacy_irq_out_n_o(legacy_irq_out_n_o),
    .legacy_irq_out_n_oe(legacy_irq_out_n_oe), .compat_to_secondary(compat_to_secondary),
    .hotplug_single_slot_mode_a(hotplug_single_slot_mode_a),
    .hotplug_single_slot_mode_b(hotplug_single_slot_mode_b), .nmi_req(nmi_req), .irq(irq));

// ===== tb/bsic_top_bench.sv
// self-checking bench for the strap and interrupt configuration block
module bsic_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pg_on = 1'b0;
    logic host_compat_req = 1'b1;
    logic perr_a_n = 1'b1;
    logic serr_a_n = 1'b1;
    logic perr_b_n = 1'b1;
    logic serr_b_n = 1'b1;
    logic [3:0] irq_a_n = 4'hf;
    logic [3:0] irq_b_n = 4'hf;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic power_good, sic, gnt2_n, sil_n, sod, compat_s, fa, fb;
    logic to_sec, mode_a, mode_b, nmi_req, irq;
    logic [3:0] buffer_delay_value, od_o, od_oe, line_n;
    logic [31:0] reg_rdata;
    int n_fail = 0;
    int num_checks = 0;
    always #2 core_clk = ~core_clk;
    bsic_board bsic_board_inst (.pg_on(pg_on), .line_o(od_o), .line_oe(od_oe),
        .power_good(power_good), .sic(sic), .gnt2_n(gnt2_n), .sil_n(sil_n), .sod(sod),
        .compat_s(compat_s), .fa(fa), .fb(fb), .buffer_delay_value(buffer_delay_value), .line_n(line_n));
    bsic_top bsic_top_inst (.core_clk(core_clk), .rst_n(rst_n), .power_good(power_good),
        .hotplug_serial_in_clock(sic), .bridge_b_grant2_n(gnt2_n),
        .hotplug_serial_load_n(sil_n), .hotplug_serial_out_data(sod), .compat_strap(compat_s),
        .freq_strap_a(fa), .freq_strap_b(fb), .buffer_delay_strap(buffer_delay_value),
        .slot_irq_in_a_n(irq_a_n), .slot_irq_in_b_n(irq_b_n), .perr_a_n(perr_a_n),
        .serr_a_n(serr_a_n), .perr_b_n(perr_b_n), .serr_b_n(serr_b_n),
        .host_compat_req(host_compat_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .legacy_irq_out_n_o(od_o),
        .legacy_irq_out_n_oe(od_oe), .compat_to_secondary(to_sec),
        .hotplug_single_slot_mode_a(mode_a), .hotplug_single_slot_mode_b(mode_b),
        .nmi_req(nmi_req), .irq(irq));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata, exp);
    endtask
    // let slot inputs cross the synchroniser, then sample the lines
    task automatic settle();
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    initial begin
        logic got;
        int cnt;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(bsic_pkg::BSIC_MISC_TWO_OFS, 32'h0);
        rd(bsic_pkg::BSIC_MISC_TWO_B_OFS, 32'h0);
        rd(8'h70, 32'h0);
        @(posedge core_clk);
        pg_on <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(bsic_pkg::BSIC_STRAP_OFS, 32'h70d);
        rd(bsic_pkg::BSIC_MISC_A_OFS, 32'h3);
        rd(bsic_pkg::BSIC_MISC_B_OFS, 32'h5);
        chk(mode_a, 1'b1);
        chk(mode_b, 1'b0);
        wr(bsic_pkg::BSIC_STRAP_OFS, 32'hffff_f0f2);
        rd(bsic_pkg::BSIC_STRAP_OFS, 32'h70c);
        chk(to_sec, 1'b0);
        wr(bsic_pkg::BSIC_STRAP_OFS, 32'h1);
        @(negedge core_clk);
        chk(to_sec, 1'b1);
        wr(bsic_pkg::BSIC_MISC_TWO_OFS, 32'hdead_beee);
        rd(bsic_pkg::BSIC_MISC_TWO_OFS, 32'hdead_beee);
        wr(bsic_pkg::BSIC_MASK_OFS, 32'h11);
        irq_a_n <= 4'he;
        settle();
        chk(od_oe, 4'h1);
        chk(line_n, 4'he);
        wr(bsic_pkg::BSIC_MISC_A_OFS, 32'hffff_fffe);
        rd(bsic_pkg::BSIC_MISC_A_OFS, 32'h2);
        settle();
        chk(od_oe, 4'h0);
        chk(line_n, 4'hf);
        irq_b_n <= 4'he;
        settle();
        chk(od_oe, 4'h1);
        wr(bsic_pkg::BSIC_MASK_OFS, 32'h01);
        settle();
        chk(od_oe, 4'h0);
        irq_a_n <= 4'hf;
        irq_b_n <= 4'hf;
        rd(bsic_pkg::BSIC_IRQ_STATUS_OFS, 32'h4);
        wr(bsic_pkg::BSIC_IRQ_ENABLE_OFS, 32'h4);
        @(negedge core_clk);
        chk(irq, 1'b1);
        wr(bsic_pkg::BSIC_IRQ_ENABLE_OFS, 32'h0);
        @(negedge core_clk);
        chk(irq, 1'b0);
        wr(bsic_pkg::BSIC_IRQ_ENABLE_OFS, 32'h5);
        wr(bsic_pkg::BSIC_IRQ_CLEAR_OFS, 32'h4);
        @(negedge core_clk);
        chk(irq, 1'b0);
        wr(bsic_pkg::BSIC_MISC_TWO_OFS, 32'h1);
        @(posedge core_clk);
        perr_a_n <= 1'b0;
        got = 1'b0;
        for (int i = 0; i < 8 && !got; i++) begin
            @(negedge core_clk);
            got = (nmi_req === 1'b1);
        end
        chk(got, 1'b1);
        @(posedge core_clk);
        perr_a_n <= 1'b1;
        rd(bsic_pkg::BSIC_IRQ_STATUS_OFS, 32'h1);
        chk(irq, 1'b1);
        wr(bsic_pkg::BSIC_MISC_TWO_OFS, 32'h0);
        serr_a_n <= 1'b0;
        cnt = 0;
        repeat (8) begin
            @(negedge core_clk);
            cnt += (nmi_req === 1'b1) ? 1 : 0;
        end
        chk(cnt, 32'h0);
        wr(bsic_pkg::BSIC_MISC_TWO_B_OFS, 32'h1);
        perr_b_n <= 1'b0;
        got = 1'b0;
        for (int i = 0; i < 8 && !got; i++) begin
            @(negedge core_clk);
            got = (nmi_req === 1'b1);
        end
        chk(got, 1'b1);
        @(posedge core_clk);
        perr_b_n <= 1'b1;
        rd(bsic_pkg::BSIC_IRQ_STATUS_OFS, 32'h3);
        give_verdict();
    end
endmodule
